// ===== common/hci_defines.vh
// Purpose: shared constants for the host command interpreter
// Assumes: one 100 MHz clock, byte-wide link framer on the same clock
// Notes:   24-bit registers, page 0 held locally, other pages reached outside
//
// Summary of operation
// - instruction byte (top bits 11) aborts and restarts
// - field bit 5 picks control or calibration
// - codes 00001 reset, 00010 standby, 00011 wake
// - codes 10100 single, 10101 continuous conversion
// - calibration type in 4:3, channels in 2:0
// - checksum off after reset, enabled by bit
// - checksum byte follows command and data bytes
// - checksum is 0xff minus each byte, wrapping
// - execute only when received checksum matches
// - mismatch sets fault, drops command, clears parser
// - 128 ms without next byte resets interface
// - command top bits: read, write, page, instruction
// - 12-bit address from page and command address
// - register read returns three data bytes
`ifndef HCI_DEFINES_VH
`define HCI_DEFINES_VH

// command function codes, top two bits of the first byte
`define HCI_FN_READ       2'h0
`define HCI_FN_WRITE      2'h1
`define HCI_FN_PAGE       2'h2
`define HCI_FN_INSTR      2'h3

// control instruction codes, field bits 4:0
`define HCI_CTL_SOFT_RST  5'h01
`define HCI_CTL_STANDBY   5'h02
`define HCI_CTL_WAKEUP    5'h03
`define HCI_CTL_SINGLE    5'h14
`define HCI_CTL_CONTIN    5'h15

// field bit that selects calibration over control
`define HCI_CLASS_BIT     5

// page 0 register offsets
`define HCI_OFS_CFG_A     6'h00
`define HCI_OFS_CFG_B     6'h01
`define HCI_OFS_MASK      6'h03
`define HCI_OFS_PHASE     6'h05
`define HCI_OFS_LINK      6'h07
`define HCI_OFS_PDUR      6'h08
`define HCI_OFS_PCTL      6'h09
`define HCI_OFS_ISTAT     6'h17
`define HCI_OFS_STAT1     6'h18
`define HCI_OFS_STAT2     6'h19
`define HCI_OFS_LOCK      6'h22
`define HCI_OFS_VA_PEAK   6'h24
`define HCI_OFS_IA_PEAK   6'h25
`define HCI_OFS_VB_PEAK   6'h26
`define HCI_OFS_IB_PEAK   6'h27
`define HCI_OFS_PSEQ      6'h30
`define HCI_PAGE_ZERO     6'h00

// page 0 reset values
`define HCI_RST_CFG_A     24'hc02000
`define HCI_RST_CFG_B     24'h00eeee
`define HCI_RST_MASK      24'h000000
`define HCI_RST_PHASE     24'h000000
`define HCI_RST_LINK      24'h02004d
`define HCI_RST_PDUR      24'h000001
`define HCI_RST_PCTL      24'h000000
`define HCI_RST_ISTAT     24'h800000
`define HCI_RST_STAT1     24'h801800
`define HCI_RST_STAT2     24'h000000
`define HCI_RST_LOCK      24'h000000
`define HCI_RST_PSEQ      24'h000000
`define HCI_ZERO_WORD     24'h000000

// field positions
`define HCI_CSUM_EN_BIT   18
`define HCI_CSUM_ERR_BIT  17

// checksum seed and byte counts
`define HCI_CSUM_SEED     8'hff
`define HCI_DATA_LAST     2'h2
`define HCI_TX_CSUM_IDX   2'h3

// inactivity timeout
`define HCI_TIMEOUT_MS    128
`define HCI_CLK_KHZ       100000
`define HCI_TIMEOUT_CYC   (`HCI_TIMEOUT_MS * `HCI_CLK_KHZ)
`define HCI_TMR_W         24

`endif

// ===== rtl/hci_timeout.v
// Purpose: inactivity timer for the command parser
// Assumes: kick and run come from logic on the same clock
// Notes:   expired is a one-cycle pulse, counter restarts after it
`timescale 1ns/10ps
`include "hci_defines.vh"

module hci_timeout #(
	parameter LIMIT = `HCI_TIMEOUT_CYC,	// cycles of silence allowed
	parameter CNT_W = `HCI_TMR_W	// counter width
) (
	input  wire       clk,	// system clock
	input  wire       rst,	// synchronous reset, high
	input  wire       run,	// parser waits for a further byte
	input  wire       kick,	// a byte arrived this cycle
	output reg        expired	// pulse when the wait ran out
);

	localparam integer     LAST_I = LIMIT - 1;	// final count, full width
	localparam [CNT_W-1:0] LAST = LAST_I[CNT_W-1:0];	// final count value

	reg [CNT_W-1:0] count;	// cycles since the last byte

	// count idle cycles while a transfer is open, restart on every byte
	always @(posedge clk) begin
		if (rst) begin
			count   <= {CNT_W{1'b0}};
			expired <= 1'b0;
		end else if (!run || kick) begin
			count   <= {CNT_W{1'b0}};
			expired <= 1'b0;
		end else if (count == LAST) begin
			count   <= {CNT_W{1'b0}};
			expired <= 1'b1;
		end else begin
			count   <= count + 1'b1;
			expired <= 1'b0;
		end
	end

endmodule

// ===== rtl/hci_top.v
// Purpose: host command interpreter with page 0 register file
// Assumes: rx and tx bytes come from a framer on the same clock
// Notes:   other pages are reached through the ext_ port group
`timescale 1ns/10ps
`include "hci_defines.vh"

module hci_top #(
	parameter TIMEOUT_CYCLES = `HCI_TIMEOUT_CYC	// inactivity limit in cycles
) (
	input  wire        clk,	// system clock
	input  wire        rst,	// synchronous reset, high
	input  wire        rx_valid,	// received byte strobe
	input  wire [7:0]  rx_byte,	// received byte
	output reg  [7:0]  tx_byte,	// byte to send
	output wire        tx_valid,	// tx_byte is offered
	input  wire        tx_ready,	// framer takes tx_byte
	output reg         instr_abort,	// running process must stop
	output reg         ctl_soft_reset,	// soft reset pulse
	output reg         ctl_standby,	// standby pulse
	output reg         ctl_wakeup,	// wakeup pulse
	output reg         ctl_single_conv,	// single conversion pulse
	output reg         ctl_continuous_conv,	// continuous conversion pulse
	output reg         cal_start,	// calibration start pulse
	output reg  [1:0]  cal_type,	// calibration type
	output reg  [2:0]  cal_channel,	// calibration channel select
	input  wire [23:0] istat_set,	// interrupt status event bits
	input  wire [23:0] stat1_set,	// chip status one event bits
	input  wire [23:0] stat2_set,	// chip status two event bits
	input  wire [23:0] va_peak,	// voltage a peak value
	input  wire [23:0] ia_peak,	// current a peak value
	input  wire [23:0] vb_peak,	// voltage b peak value
	input  wire [23:0] ib_peak,	// current b peak value
	output reg  [11:0] ext_addr,	// address of the current access
	output reg         ext_wr,	// write strobe for other pages
	output reg  [23:0] ext_wdata,	// write data for other pages
	input  wire [23:0] ext_rdata,	// read data for ext_addr
	output reg  [5:0]  page_sel,	// selected page
	output reg  [23:0] main_configuration_a,	// configuration a
	output reg  [23:0] main_configuration_b,	// configuration b
	output reg  [23:0] interrupt_mask,	// interrupt mask
	output reg  [23:0] phase_compensation,	// phase compensation
	output reg  [23:0] link_control,	// link control
	output reg  [23:0] energy_pulse_duration,	// pulse width
	output reg  [23:0] energy_pulse_control,	// pulse control
	output reg  [23:0] write_lock_control,	// write lock control
	output reg  [23:0] phase_sequence_control,	// phase sequence control
	output reg  [23:0] interrupt_status,	// sticky interrupt status
	output reg  [23:0] chip_status_one,	// sticky chip status one
	output reg  [23:0] chip_status_two	// sticky chip status two
);

	// parser states
	localparam [2:0] ST_IDLE  = 3'h0;	// waiting for a command byte
	localparam [2:0] ST_DATA  = 3'h1;	// collecting write data
	localparam [2:0] ST_CSUM  = 3'h2;	// waiting for the checksum byte
	localparam [2:0] ST_FETCH = 3'h3;	// read data settles
	localparam [2:0] ST_SEND  = 3'h4;	// sending read data

	reg  [2:0]  state;	// parser state
	reg  [7:0]  cmd;	// latched command byte
	reg  [1:0]  cnt;	// data byte index
	reg  [23:0] data;	// collected write data
	reg  [7:0]  run;	// running receive checksum
	reg  [23:0] tx_buf;	// read word being sent
	reg  [1:0]  tx_cnt;	// index of the byte on tx_byte
	reg  [7:0]  tx_run;	// running transmit checksum
	reg         exec_go;	// command complete and accepted
	reg  [7:0]  exec_cmd;	// command being executed
	reg  [23:0] exec_data;	// data of the executed command
	reg         csum_bad;	// checksum mismatch this cycle
	reg  [23:0] rd_word;	// read value at ext_addr, page 0 or outer
	reg  [23:0] istat_clr;	// clear mask for interrupt status
	reg  [23:0] stat1_clr;	// clear mask for chip status one
	reg  [23:0] stat2_clr;	// clear mask for chip status two
	reg  [23:0] fault_set;	// checksum fault as a status bit
	wire        srst;	// device or soft reset
	wire        csum_on;	// checksum protection active
	wire        tmo;	// inactivity expiry pulse
	wire        p0_write;	// write to the local page
	wire        tx_take;	// framer accepts a byte

	// subtract one byte from a running checksum, borrow dropped
	function [7:0] hci_csum_step;
		input [7:0] acc;	// checksum so far
		input [7:0] b;	// byte on the wire
		begin
			hci_csum_step = acc - b;
		end
	endfunction

	assign srst     = rst | ctl_soft_reset;
	assign csum_on  = link_control[`HCI_CSUM_EN_BIT];
	assign tx_valid = (state == ST_SEND);
	assign tx_take  = tx_valid & tx_ready;
	assign p0_write = exec_go && (exec_cmd[7:6] == `HCI_FN_WRITE) && (page_sel == `HCI_PAGE_ZERO);

	// inactivity timer, armed only while more host bytes are due
	hci_timeout #(
		.LIMIT (TIMEOUT_CYCLES),
		.CNT_W (`HCI_TMR_W)
	) u_timeout (
		.clk     (clk),
		.rst     (srst),
		.run     ((state == ST_DATA) || (state == ST_CSUM)),
		.kick    (rx_valid),
		.expired (tmo)
	);

	// decide whether the byte now arriving completes a command
	always @* begin
		exec_go   = 1'b0;
		exec_cmd  = cmd;
		exec_data = {data[15:0], rx_byte};
		csum_bad  = 1'b0;
		if (rx_valid && !tmo) begin
			case (state)
				ST_IDLE: begin
					// single-byte commands run at once unless a checksum follows
					if (rx_byte[7:6] != `HCI_FN_WRITE && !csum_on) begin
						exec_go  = 1'b1;
						exec_cmd = rx_byte;
					end
				end
				ST_DATA: begin
					if (cnt == `HCI_DATA_LAST && !csum_on)
						exec_go = 1'b1;
				end
				ST_CSUM: begin
					// only a matching checksum lets the command through
					exec_data = data;
					if (rx_byte == run)
						exec_go = 1'b1;
					else
						csum_bad = 1'b1;
				end
				default: begin
					exec_go = 1'b0;
				end
			endcase
		end
	end

	// command byte parser and read data sender
	always @(posedge clk) begin
		if (srst) begin
			state  <= ST_IDLE;
			cmd    <= 8'h00;
			cnt    <= 2'h0;
			data   <= 24'h000000;
			run    <= `HCI_CSUM_SEED;
			tx_buf <= 24'h000000;
			tx_cnt <= 2'h0;
			tx_run <= `HCI_CSUM_SEED;
			tx_byte <= 8'h00;
		end else if (tmo) begin
			state <= ST_IDLE;
			cnt   <= 2'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (rx_valid) begin
						cmd <= rx_byte;
						cnt <= 2'h0;
						run <= hci_csum_step(`HCI_CSUM_SEED, rx_byte);
						if (rx_byte[7:6] == `HCI_FN_WRITE)
							state <= ST_DATA;
						else if (csum_on)
							state <= ST_CSUM;
						else if (rx_byte[7:6] == `HCI_FN_READ)
							state <= ST_FETCH;
					end
				end
				ST_DATA: begin
					// gather three data bytes, most significant first
					if (rx_valid) begin
						data <= exec_data;
						cnt  <= cnt + 2'h1;
						run  <= hci_csum_step(run, rx_byte);
						if (cnt == `HCI_DATA_LAST)
							state <= csum_on ? ST_CSUM : ST_IDLE;
					end
				end
				ST_CSUM: begin
					if (rx_valid) begin
						if (exec_go && exec_cmd[7:6] == `HCI_FN_READ)
							state <= ST_FETCH;
						else
							state <= ST_IDLE;
					end
				end
				ST_FETCH: begin
					// capture the addressed word and offer its top byte
					tx_buf  <= rd_word;
					tx_byte <= rd_word[23:16];
					tx_cnt  <= 2'h0;
					tx_run  <= hci_csum_step(`HCI_CSUM_SEED, rd_word[23:16]);
					state   <= ST_SEND;
				end
				ST_SEND: begin
					if (tx_take) begin
						if (tx_cnt == 2'h0) begin
							tx_byte <= tx_buf[15:8];
							tx_run  <= hci_csum_step(tx_run, tx_buf[15:8]);
							tx_cnt  <= 2'h1;
						end else if (tx_cnt == 2'h1) begin
							tx_byte <= tx_buf[7:0];
							tx_run  <= hci_csum_step(tx_run, tx_buf[7:0]);
							tx_cnt  <= `HCI_DATA_LAST;
						end else if (tx_cnt == `HCI_DATA_LAST && csum_on) begin
							tx_byte <= tx_run;
							tx_cnt  <= `HCI_TX_CSUM_IDX;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// page 0 read decode, reserved offsets give zero
	always @* begin
		case (ext_addr[5:0])
			`HCI_OFS_CFG_A:   rd_word = main_configuration_a;
			`HCI_OFS_CFG_B:   rd_word = main_configuration_b;
			`HCI_OFS_MASK:    rd_word = interrupt_mask;
			`HCI_OFS_PHASE:   rd_word = phase_compensation;
			`HCI_OFS_LINK:    rd_word = link_control;
			`HCI_OFS_PDUR:    rd_word = energy_pulse_duration;
			`HCI_OFS_PCTL:    rd_word = energy_pulse_control;
			`HCI_OFS_ISTAT:   rd_word = interrupt_status;
			`HCI_OFS_STAT1:   rd_word = chip_status_one;
			`HCI_OFS_STAT2:   rd_word = chip_status_two;
			`HCI_OFS_LOCK:    rd_word = write_lock_control;
			`HCI_OFS_VA_PEAK: rd_word = va_peak;
			`HCI_OFS_IA_PEAK: rd_word = ia_peak;
			`HCI_OFS_VB_PEAK: rd_word = vb_peak;
			`HCI_OFS_IB_PEAK: rd_word = ib_peak;
			`HCI_OFS_PSEQ:    rd_word = phase_sequence_control;
			default:          rd_word = `HCI_ZERO_WORD;
		endcase
		if (ext_addr[11:6] != `HCI_PAGE_ZERO)
			rd_word = ext_rdata;
	end

	// clear masks for the sticky status words, written ones clear
	always @* begin
		istat_clr = 24'h000000;
		stat1_clr = 24'h000000;
		stat2_clr = 24'h000000;
		fault_set = 24'h000000;
		fault_set[`HCI_CSUM_ERR_BIT] = csum_bad;
		if (p0_write) begin
			case (exec_cmd[5:0])
				`HCI_OFS_ISTAT: istat_clr = exec_data;
				`HCI_OFS_STAT1: stat1_clr = exec_data;
				`HCI_OFS_STAT2: stat2_clr = exec_data;
				default:        istat_clr = 24'h000000;
			endcase
		end
	end

	// page 0 register file, page pointer and remote access port
	always @(posedge clk) begin
		if (srst) begin
			main_configuration_a   <= `HCI_RST_CFG_A;
			main_configuration_b   <= `HCI_RST_CFG_B;
			interrupt_mask         <= `HCI_RST_MASK;
			phase_compensation     <= `HCI_RST_PHASE;
			link_control           <= `HCI_RST_LINK;
			energy_pulse_duration  <= `HCI_RST_PDUR;
			energy_pulse_control   <= `HCI_RST_PCTL;
			write_lock_control     <= `HCI_RST_LOCK;
			phase_sequence_control <= `HCI_RST_PSEQ;
			interrupt_status       <= `HCI_RST_ISTAT;
			chip_status_one        <= `HCI_RST_STAT1;
			chip_status_two        <= `HCI_RST_STAT2;
			page_sel               <= `HCI_PAGE_ZERO;
			ext_addr               <= 12'h000;
			ext_wr                 <= 1'b0;
			ext_wdata              <= 24'h000000;
		end else begin
			// events win over a clear in the same cycle
			interrupt_status <= (interrupt_status & ~istat_clr) | istat_set | fault_set;
			chip_status_one  <= (chip_status_one & ~stat1_clr) | stat1_set;
			chip_status_two  <= (chip_status_two & ~stat2_clr) | stat2_set;
			ext_wr <= 1'b0;
			if (exec_go) begin
				case (exec_cmd[7:6])
					`HCI_FN_PAGE: begin
						page_sel <= exec_cmd[5:0];
					end
					`HCI_FN_READ: begin
						ext_addr <= {page_sel, exec_cmd[5:0]};
					end
					`HCI_FN_WRITE: begin
						ext_addr  <= {page_sel, exec_cmd[5:0]};
						ext_wdata <= exec_data;
						ext_wr    <= (page_sel != `HCI_PAGE_ZERO);
					end
					default: begin
						ext_wr <= 1'b0;
					end
				endcase
			end
			if (p0_write) begin
				// reserved and read-only offsets fall to the default
				case (exec_cmd[5:0])
					`HCI_OFS_CFG_A: main_configuration_a   <= exec_data;
					`HCI_OFS_CFG_B: main_configuration_b   <= exec_data;
					`HCI_OFS_MASK:  interrupt_mask         <= exec_data;
					`HCI_OFS_PHASE: phase_compensation     <= exec_data;
					`HCI_OFS_LINK:  link_control           <= exec_data;
					`HCI_OFS_PDUR:  energy_pulse_duration  <= exec_data;
					`HCI_OFS_PCTL:  energy_pulse_control   <= exec_data;
					`HCI_OFS_LOCK:  write_lock_control     <= exec_data;
					`HCI_OFS_PSEQ:  phase_sequence_control <= exec_data;
					default:        ext_wr                 <= 1'b0;
				endcase
			end
		end
	end

	// instruction decode into one-cycle strobes for the engines
	always @(posedge clk) begin
		if (rst) begin
			instr_abort         <= 1'b0;
			ctl_soft_reset      <= 1'b0;
			ctl_standby         <= 1'b0;
			ctl_wakeup          <= 1'b0;
			ctl_single_conv     <= 1'b0;
			ctl_continuous_conv <= 1'b0;
			cal_start           <= 1'b0;
			cal_type            <= 2'h0;
			cal_channel         <= 3'h0;
		end else begin
			instr_abort         <= 1'b0;
			ctl_soft_reset      <= 1'b0;
			ctl_standby         <= 1'b0;
			ctl_wakeup          <= 1'b0;
			ctl_single_conv     <= 1'b0;
			ctl_continuous_conv <= 1'b0;
			cal_start           <= 1'b0;
			if (exec_go && exec_cmd[7:6] == `HCI_FN_INSTR && !ctl_soft_reset) begin
				instr_abort <= 1'b1;
				if (exec_cmd[`HCI_CLASS_BIT]) begin
					// calibration: type and channel ride with the strobe
					cal_start   <= 1'b1;
					cal_type    <= exec_cmd[4:3];
					cal_channel <= exec_cmd[2:0];
				end else begin
					case (exec_cmd[4:0])
						`HCI_CTL_SOFT_RST: ctl_soft_reset      <= 1'b1;
						`HCI_CTL_STANDBY:  ctl_standby         <= 1'b1;
						`HCI_CTL_WAKEUP:   ctl_wakeup          <= 1'b1;
						`HCI_CTL_SINGLE:   ctl_single_conv     <= 1'b1;
						`HCI_CTL_CONTIN:   ctl_continuous_conv <= 1'b1;
						default:           ctl_standby         <= 1'b0;
					endcase
				end
			end
		end
	end

endmodule

// ===== testbench/hci_top_chk.sv
// Purpose: port-level temporal checks for the command interpreter
// Assumes: one clock, synchronous active-high reset
// Notes:   attached to every hci_top instance by the bind below
`timescale 1ns/10ps
module hci_top_chk #(
	parameter TIMEOUT_CYCLES = 50	// inactivity limit, kept in step
) (
	input wire        clk,	// system clock
	input wire        rst,	// sync reset
	input wire        rx_valid,	// byte strobe
	input wire [7:0]  rx_byte,	// received byte
	input wire [7:0]  tx_byte,	// reply byte
	input wire        tx_valid,	// reply offered
	input wire        tx_ready,	// reply taken
	input wire        instr_abort,	// abort pulse
	input wire        ctl_soft_reset,	// soft reset pulse
	input wire        ctl_standby,	// standby pulse
	input wire        ctl_wakeup,	// wakeup pulse
	input wire        ctl_single_conv,	// single conversion
	input wire        ctl_continuous_conv,	// continuous conversion
	input wire        cal_start,	// calibration pulse
	input wire [1:0]  cal_type,	// calibration type
	input wire [2:0]  cal_channel,	// channel select
	input wire [23:0] istat_set,	// status events
	input wire [11:0] ext_addr,	// access address
	input wire        ext_wr,	// outer page write
	input wire [5:0]  page_sel,	// current page
	input wire [23:0] link_control,	// link control
	input wire [23:0] interrupt_status	// sticky status
);
	default clocking dcb @(posedge clk); endclocking
	default disable iff (rst);
	// reply offered while the host stalls
	sequence stall_s;
		tx_valid && !tx_ready;
	endsequence
	// strobe traced back to its command byte when no checksum is in use
	property code_p(logic s, logic [7:0] c);
		s && !$past(link_control[18]) |-> $past(rx_valid) && $past(rx_byte) == c;
	endproperty
	soft_code_a: assert property (code_p(ctl_soft_reset, 8'hc1))
		else $error("soft reset without its code");
	standby_code_a: assert property (code_p(ctl_standby, 8'hc2))
		else $error("standby without its code");
	wake_code_a: assert property (code_p(ctl_wakeup, 8'hc3))
		else $error("wakeup without its code");
	single_code_a: assert property (code_p(ctl_single_conv, 8'hd4))
		else $error("single conversion without its code");
	cont_code_a: assert property (code_p(ctl_continuous_conv, 8'hd5))
		else $error("continuous conversion without its code");
	abort_cause_a: assert property (instr_abort && !$past(link_control[18]) |->
		$past(rx_valid) && $past(rx_byte[7:6]) == 2'h3) else $error("abort without instruction");
	strobe_abort_a: assert property (ctl_soft_reset || ctl_standby || ctl_wakeup ||
		ctl_single_conv || ctl_continuous_conv || cal_start |-> instr_abort)
		else $error("strobe without abort");
	cal_fields_a: assert property (cal_start && !$past(link_control[18]) |->
		$past(rx_byte[5]) && {cal_type, cal_channel} == $past(rx_byte[4:0]))
		else $error("calibration fields wrong");
	reply_hold_a: assert property (stall_s |=> tx_valid && $stable(tx_byte))
		else $error("reply changed while stalled");
	outer_write_a: assert property (ext_wr |-> page_sel != 6'h00 &&
		ext_addr[11:6] == page_sel) else $error("outer write with bad page");
	fault_cause_a: assert property ($rose(interrupt_status[17]) |->
		$past(istat_set[17]) || ($past(rx_valid) || $past(rx_valid, 2)) && link_control[18])
		else $error("checksum fault without cause");
	fault_drop_a: assert property ($rose(interrupt_status[17]) && !$past(istat_set[17]) |->
		!instr_abort && !ext_wr ##1 !instr_abort && !ext_wr) else $error("bad command ran");
	reset_state_a: assert property (disable iff (1'b0) rst |=> !tx_valid &&
		page_sel == 6'h00 && link_control == 24'h02004d) else $error("reset state wrong");
endmodule

bind hci_top hci_top_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (
	.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_byte(tx_byte),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .instr_abort(instr_abort),
	.ctl_soft_reset(ctl_soft_reset), .ctl_standby(ctl_standby), .ctl_wakeup(ctl_wakeup),
	.ctl_single_conv(ctl_single_conv), .ctl_continuous_conv(ctl_continuous_conv),
	.cal_start(cal_start), .cal_type(cal_type), .cal_channel(cal_channel),
	.istat_set(istat_set), .ext_addr(ext_addr), .ext_wr(ext_wr), .page_sel(page_sel),
	.link_control(link_control), .interrupt_status(interrupt_status));

// ===== testbench/hci_host_model.sv
// Purpose: host side byte source and reply sink
// Assumes: bytes framed elsewhere, one byte per strobe
// Notes:   idle data line shows the inverse of the last byte
`timescale 1ns/10ps
module hci_host_model (
	input  wire       clk,	// system clock
	output logic      rx_valid,	// byte strobe to device
	output logic [7:0] rx_byte,	// byte to device
	input  wire [7:0] tx_byte,	// reply byte
	input  wire       tx_valid,	// reply offered
	output logic      tx_ready	// reply taken
);
	logic [7:0] sum;	// running checksum of bytes sent
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		tx_ready = 1'b0;
		sum = 8'hff;
	end
	// one byte for one cycle, well inside the inactivity limit
	task send(input logic [7:0] b);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_byte = b;
		sum = sum - b;
		@(negedge clk);
		rx_valid = 1'b0;
		rx_byte = ~b;
	endtask
	// append the checksum of everything sent since the command
	task close;
		logic [7:0] c;
		c = sum;
		send(c);
	endtask
	// take one reply byte after stalling the given number of cycles
	task get(input int stall, output logic [7:0] b);
		int n;
		n = 0;
		while (tx_valid !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		repeat (stall) @(negedge clk);
		tx_ready = 1'b1;
		b = tx_byte;
		@(negedge clk);
		tx_ready = 1'b0;
	endtask
endmodule

// ===== testbench/hci_top_tb.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: host model drives bytes on falling edges
// Notes:   inactivity limit shortened to 50 cycles
`timescale 1ns/10ps
module hci_top_tb;
	logic        clk = 1'b0;	// system clock
	logic        rst = 1'b1;	// sync reset
	logic        csum_on = 1'b0;	// bench copy of checksum enable
	logic [23:0] istat_set = 24'h0;	// status events
	logic [23:0] peak = 24'h5a0f3c;	// peak source
	integer      fail_count = 0;	// mismatches
	integer      checked = 0;	// comparisons
	integer      cycles = 0;	// watchdog
	wire         rx_valid, tx_valid, tx_ready, instr_abort, ext_wr, cal_start;
	wire         ctl_soft_reset, ctl_standby, ctl_wakeup, ctl_single_conv, ctl_continuous_conv;
	wire [7:0]   rx_byte, tx_byte;	// link bytes
	wire [1:0]   cal_type;	// calibration type
	wire [2:0]   cal_channel;	// channel select
	wire [11:0]  ext_addr;	// access address
	wire [23:0]  ext_wdata;	// outer write data
	// strobes packed as {type, channel, abort, soft, stby, wake, single, cont, cal}
	wire [11:0]  strobes = {cal_start ? {cal_type, cal_channel} : 5'h0, instr_abort,
		ctl_soft_reset, ctl_standby, ctl_wakeup, ctl_single_conv, ctl_continuous_conv, cal_start};
	// rows: command byte beside strobe pattern or register value
	logic [31:0] rows [0:23] = '{32'hc1000060, 32'hc2000050, 32'hc3000048, 32'hd4000044,
		32'hd5000042, 32'hc0000040, 32'he10000c1, 32'hf2000941, 32'hfb000dc1,
		32'h00c02000, 32'h0100eeee, 32'h02000000, 32'h03000000, 32'h05000000,
		32'h0702004d, 32'h08000001, 32'h09000000, 32'h17800000, 32'h18801800,
		32'h19000000, 32'h22000000, 32'h245a0f3c, 32'h25a5f0c3, 32'h30000000};

	always #5 clk = ~clk;

	hci_host_model host_u (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));

	hci_top #(.TIMEOUT_CYCLES(50)) dut_u (.clk(clk), .rst(rst), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.instr_abort(instr_abort), .ctl_soft_reset(ctl_soft_reset), .ctl_standby(ctl_standby),
		.ctl_wakeup(ctl_wakeup), .ctl_single_conv(ctl_single_conv),
		.ctl_continuous_conv(ctl_continuous_conv), .cal_start(cal_start), .cal_type(cal_type),
		.cal_channel(cal_channel), .istat_set(istat_set), .stat1_set(istat_set),
		.stat2_set(istat_set),
		.va_peak(peak), .ia_peak(~peak), .vb_peak(peak ^ 24'h00ffff), .ib_peak(peak ^ 24'hff0000),
		.ext_addr(ext_addr), .ext_wr(ext_wr), .ext_wdata(ext_wdata),
		.ext_rdata({ext_addr, ext_addr}), .page_sel(), .main_configuration_a(),
		.main_configuration_b(), .interrupt_mask(), .phase_compensation(), .link_control(),
		.energy_pulse_duration(), .energy_pulse_control(), .write_lock_control(),
		.phase_sequence_control(), .interrupt_status(), .chip_status_one(), .chip_status_two());

	// compare any result, counting and reporting mismatches
	task cmp(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// command byte, optional three data bytes, checksum when enabled
	task xfer(input logic [7:0] c, input logic [23:0] d, input logic dat);
		host_u.sum = 8'hff;
		host_u.send(c);
		if (dat) begin
			host_u.send(d[23:16]);
			host_u.send(d[15:8]);
			host_u.send(d[7:0]);
		end
		if (csum_on) host_u.close();
	endtask
	// read a register, stalling more on each byte, and check reply, and checksum when enabled
	task rd(input logic [5:0] a, input logic [23:0] e);
		logic [7:0]  b;
		logic [7:0]  s;
		logic [23:0] v;
		integer      i;
		xfer({2'h0, a}, 24'h0, 1'b0);
		s = 8'hff;
		for (i = 0; i < 3; i++) begin
			host_u.get(i, b);
			v = {v[15:0], b};
			s = s - b;
		end
		cmp(v, e);
		if (csum_on) begin
			host_u.get(0, b);
			cmp({16'h0, b}, {16'h0, s});
		end
	endtask
	task give_verdict;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// cut a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			fail_count++;
			give_verdict();
		end
	end

	initial begin
		integer i;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		for (i = 0; i < 24; i++) begin
			if (rows[i][31:30] == 2'h3) begin
				xfer(rows[i][31:24], 24'h0, 1'b0);
				cmp({12'h0, strobes}, rows[i][23:0]);
				repeat (2) @(negedge clk);
			end else begin
				rd(rows[i][29:24], rows[i][23:0]);
			end
		end
		xfer(8'h43, 24'h123456, 1'b1);
		rd(6'h03, 24'h123456);
		xfer(8'h42, 24'hffffff, 1'b1);
		rd(6'h02, 24'h000000);
		xfer(8'h64, 24'h111111, 1'b1);
		rd(6'h24, 24'h5a0f3c);
		peak = 24'h123abc;
		rd(6'h27, 24'hed3abc);
		// sticky status: event, then write one to clear
		@(negedge clk) istat_set = 24'h000001;
		@(negedge clk) istat_set = 24'h000000;
		rd(6'h17, 24'h800001);
		xfer(8'h57, 24'h000001, 1'b1);
		rd(6'h17, 24'h800000);
		// outer page write and read
		xfer(8'h90, 24'h0, 1'b0);
		xfer(8'h45, 24'h0a0b0c, 1'b1);
		cmp({11'h0, ext_wr, ext_addr}, 24'h001405);
		cmp(ext_wdata, 24'h0a0b0c);
		rd(6'h05, 24'h405405);
		xfer(8'h80, 24'h0, 1'b0);
		// silence beyond the limit drops a partial write
		host_u.send(8'h43);
		host_u.send(8'h99);
		repeat (60) @(negedge clk);
		rd(6'h03, 24'h123456);
		// gaps below the limit restart the timer each byte
		host_u.send(8'h43);
		host_u.send(8'h11);
		repeat (40) @(negedge clk);
		host_u.send(8'h22);
		repeat (40) @(negedge clk);
		host_u.send(8'h33);
		rd(6'h03, 24'h112233);
		// checksum on: good, then bad instruction
		xfer(8'h47, 24'h06004d, 1'b1);
		csum_on = 1'b1;
		rd(6'h07, 24'h06004d);
		xfer(8'hd4, 24'h0, 1'b0);
		cmp({12'h0, strobes}, 24'h000044);
		host_u.send(8'hd4);
		host_u.send(8'h00);
		cmp({12'h0, strobes}, 24'h000000);
		rd(6'h17, 24'h820000);
		xfer(8'h57, 24'h020000, 1'b1);
		xfer(8'hc1, 24'h0, 1'b0);
		repeat (2) @(negedge clk);
		csum_on = 1'b0;
		rd(6'h07, 24'h02004d);
		rd(6'h03, 24'h000000);
		give_verdict();
	end
endmodule
